// ==== logic/odsd_diag_filter.sv ====
// diagnostic status filter: passes a level only after it held long enough
`timescale 1ns/1ps
`default_nettype none
module odsd_diag_filter #(
  parameter int FILT_CYC = 1875
) (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic rawIn,
  output logic      filtOut
);
  localparam int CW = $clog2(FILT_CYC + 1);
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          out_reg;
  logic          out_next;

  if (FILT_CYC < 1) begin : g_bad_count
    $error("odsd_diag_filter: FILT_CYC below one");
  end

  always_comb begin
    cnt_next = '0;
    out_next = out_reg;
    if (rawIn != out_reg) begin
      if (cnt_reg == CW'(FILT_CYC - 1)) begin
        out_next = rawIn;
      end else begin
        cnt_next = cnt_reg + CW'(1);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      cnt_reg <= '0;
      // healthy status idles high
      out_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_next;
      out_reg <= out_next;
    end
  end

  assign filtOut = out_reg;
endmodule // odsd_diag_filter
`default_nettype wire

// ==== logic/odsd_pkg.sv ====
// shared constants for the octal driver serial control and diagnostic block
package odsd_pkg;
  localparam int NUM_OUT      = 8;
  localparam int CLK_PERIOD_NS = 8;
  // sdo release after select rises, longest time
  localparam int SDO_FLOAT_NS = 100;
  localparam int SDO_FLOAT_CYC =
    (SDO_FLOAT_NS / CLK_PERIOD_NS) < 1 ? 1 : SDO_FLOAT_NS / CLK_PERIOD_NS;
  // diagnostic detection filter, 15 to 50 us; the least time is used
  localparam int DIAG_FILT_US = 15;
  localparam int DIAG_FILT_CYC =
    (DIAG_FILT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FRAME_BITS   = 8;
  localparam int FRAME_CNT_W  = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int IDX_OUT1 = 0;
  localparam int IDX_OUT2 = 1;
  localparam int IDX_OUT7 = 6;
  localparam int IDX_OUT8 = 7;
  localparam int SHORT_OFF_LAST = 5;
endpackage : odsd_pkg

// ==== logic/odsd_sync.sv ====
// two flip-flop synchroniser for a bus of pin inputs
`timescale 1ns/1ps
`default_nettype none
module odsd_sync #(
  parameter int          WIDTH = 1,
  parameter logic [31:0] INIT  = 32'h0000_0000
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // init word is 32 bits, so wider buses cannot be served
  if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
    $error("odsd_sync: bad WIDTH");
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      meta_reg <= INIT[WIDTH-1:0];
      sync_reg <= INIT[WIDTH-1:0];
    end else begin
      meta_reg <= asyncIn;
      sync_reg <= meta_reg;
    end
  end

  assign syncOut = sync_reg;
endmodule // odsd_sync
`default_nettype wire

// ==== logic/odsd_top.sv ====
// serial control, output gating and diagnostics of an octal low-side driver
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - eight control latches, common reset gates outputs
// - open parallel input reads high, output off
// - shift sdi on serial clock falling edge
// - select rising copies shift register to latches
// - latch only after multiple of eight clocks
// - parallel low or serial bit turns on
// - outputs one to six overcurrent latches off
// - outputs seven, eight overtemperature latches off
// - fault latches one, two cleared while selected
// - parallel mode status high when state matches
// - serial mode status follows output voltage
// - outputs three to eight status live
// - overcurrent sets latch, off, low status
// - off-state low voltage reports low status
// - outputs seven, eight limiting reports low
// - select falling loads status into shift register
// - sdo shifts on serial clock rising edge
// - internal reset is external or undervoltage
// - sdo floats within 100 ns of select rising
// - outputs one, two status filtered 15 us
module odsd_top #(
  parameter int DIAG_FILT_CYC = odsd_pkg::DIAG_FILT_CYC
) (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       ext_reset_n,
  input  wire logic       underVoltage,
  input  wire logic       select_n_line,
  input  wire logic       serialClk,
  input  wire logic       serialDataIn,
  output logic            serialDataOut,
  output logic            serialDataOutEn,
  input  wire logic       parallel_in_one,
  input  wire logic       parallel_in_two,
  input  wire logic [7:0] overCurrent,
  input  wire logic [7:0] overTemp,
  input  wire logic [7:0] aboveThreshold,
  output logic      [7:0] outputOn,
  output logic      [7:0] currentLimit,
  output logic      [7:0] overloadLatched,
  output logic      [7:0] controlLatch
);
  localparam int N  = odsd_pkg::NUM_OUT;
  localparam int FW = odsd_pkg::FRAME_CNT_W;

  if (N != 8) begin : g_bad_width
    $error("odsd_top: eight outputs only");
  end
  if (DIAG_FILT_CYC < 1) begin : g_bad_filter
    $error("odsd_top: filter count below one");
  end

  // pins from the link and the analog side cross into the clock domain
  logic [4:0] pinSync;
  logic       selN;
  logic       sclk;
  logic       sdi;
  logic       par1;
  logic       par2;
  logic       extResN;
  logic       uvSync;
  logic [7:0] ocSync;
  logic [7:0] otSync;
  logic [7:0] aboveSync;

  // open parallel inputs idle high
  // serial clock idles low, else reset is followed by a false edge
  odsd_sync #(.WIDTH(5), .INIT(32'h0000_001E)) uSyncPins (
    .clock  (clock),
    .reset  (reset),
    .asyncIn({select_n_line, parallel_in_one, parallel_in_two,
              ext_reset_n, serialClk}),
    .syncOut(pinSync)
  );
  assign selN    = pinSync[4];
  assign par1    = pinSync[3];
  assign par2    = pinSync[2];
  assign extResN = pinSync[1];
  assign sclk    = pinSync[0];

  odsd_sync #(.WIDTH(26), .INIT(32'h0000_0000)) uSyncData (
    .clock  (clock),
    .reset  (reset),
    .asyncIn({serialDataIn, underVoltage, overCurrent, overTemp,
              aboveThreshold}),
    .syncOut({sdi, uvSync, ocSync, otSync, aboveSync})
  );

  logic intReset;
  assign intReset = reset | ~extResN | uvSync;

  // edge detection on synchronised link signals
  logic selN_reg;
  logic sclk_reg;
  logic selFall;
  logic selRise;
  logic clkFall;
  logic clkRise;
  always_ff @(posedge clock) begin
    if (reset) begin
      selN_reg <= 1'b1;
      sclk_reg <= 1'b0;
    end else begin
      selN_reg <= selN;
      sclk_reg <= sclk;
    end
  end
  assign selFall = selN_reg & ~selN;
  assign selRise = ~selN_reg & selN;
  assign clkFall = sclk_reg & ~sclk;
  assign clkRise = ~sclk_reg & sclk;

  // status word and output logic
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [7:0] ovl_reg;
  logic [7:0] ovl_next;
  logic [7:0] drive;
  logic [7:0] status;
  logic       filt1;
  logic       filt2;
  logic       fault1_reg;
  logic       fault1_next;
  logic       fault2_reg;
  logic       fault2_next;
  logic       parMode1;
  logic       parMode2;

  // parallel low or serial bit switches on
  function automatic logic wantOn(input logic parN, input logic bit_);
    return ~parN | bit_;
  endfunction

  // parallel mode reports matching state as healthy
  function automatic logic parStatus(input logic on, input logic above);
    return on ? ~above : above;
  endfunction

  always_comb begin
    drive = ctrl_reg;
    drive[odsd_pkg::IDX_OUT1] = wantOn(par1, ctrl_reg[odsd_pkg::IDX_OUT1]);
    drive[odsd_pkg::IDX_OUT2] = wantOn(par2, ctrl_reg[odsd_pkg::IDX_OUT2]);
  end
  assign parMode1 = ~par1 & ~ctrl_reg[odsd_pkg::IDX_OUT1];
  assign parMode2 = ~par2 & ~ctrl_reg[odsd_pkg::IDX_OUT2];

  // short circuit latches outputs one to six
  // overtemperature latches outputs seven and eight
  // latch holds until reset or off command
  always_comb begin
    ovl_next = ovl_reg;
    for (int i = 0; i < N; i++) begin
      if (!drive[i]) begin
        ovl_next[i] = 1'b0;
      end
      if (i <= odsd_pkg::SHORT_OFF_LAST) begin
        if (drive[i] && ocSync[i]) ovl_next[i] = 1'b1;
      end else begin
        if (drive[i] && ocSync[i] && otSync[i]) ovl_next[i] = 1'b1;
      end
    end
  end

  // serial mode status follows output voltage
  // outputs three to eight live into register
  // off with low voltage reports low
  // outputs seven, eight limiting or tripped low
  logic [7:0] rawStatus;
  always_comb begin
    rawStatus = aboveSync;
    for (int i = 0; i < N; i++) begin
      if (ovl_reg[i]) rawStatus[i] = 1'b0;
      if (i > odsd_pkg::SHORT_OFF_LAST && drive[i] && aboveSync[i]) begin
        rawStatus[i] = 1'b0;
      end
    end
    if (parMode1 && !ovl_reg[odsd_pkg::IDX_OUT1]) begin
      rawStatus[odsd_pkg::IDX_OUT1] =
        parStatus(drive[odsd_pkg::IDX_OUT1], aboveSync[odsd_pkg::IDX_OUT1]);
    end
    if (parMode2 && !ovl_reg[odsd_pkg::IDX_OUT2]) begin
      rawStatus[odsd_pkg::IDX_OUT2] =
        parStatus(drive[odsd_pkg::IDX_OUT2], aboveSync[odsd_pkg::IDX_OUT2]);
    end
  end

  // outputs one and two pass the detection filter
  odsd_diag_filter #(.FILT_CYC(DIAG_FILT_CYC)) uFilt1 (
    .clock  (clock),
    .reset  (intReset),
    .rawIn  (rawStatus[odsd_pkg::IDX_OUT1]),
    .filtOut(filt1)
  );
  odsd_diag_filter #(.FILT_CYC(DIAG_FILT_CYC)) uFilt2 (
    .clock  (clock),
    .reset  (intReset),
    .rawIn  (rawStatus[odsd_pkg::IDX_OUT2]),
    .filtOut(filt2)
  );

  // fault latches catch lows, cleared while selected
  // a fault seen in the same cycle as the clear still wins
  always_comb begin
    fault1_next = fault1_reg;
    fault2_next = fault2_reg;
    if (!selN) begin
      fault1_next = 1'b0;
      fault2_next = 1'b0;
    end
    if (!filt1) fault1_next = 1'b1;
    if (!filt2) fault2_next = 1'b1;
  end

  // stale latch means first read may mislead
  always_comb begin
    status = rawStatus;
    status[odsd_pkg::IDX_OUT1] = ~fault1_reg;
    status[odsd_pkg::IDX_OUT2] = ~fault2_reg;
  end

  // serial frame: shift register, bit counter, sdo
  logic [7:0]    shift_reg;
  logic [7:0]    shift_next;
  logic [FW-1:0] bits_reg;
  logic [FW-1:0] bits_next;
  logic          any_reg;
  logic          any_next;
  logic          sdo_reg;
  logic          sdo_next;
  logic          sdoEn_reg;
  logic          sdoEn_next;

  always_comb begin
    shift_next = shift_reg;
    bits_next  = bits_reg;
    any_next   = any_reg;
    sdo_next   = sdo_reg;
    sdoEn_next = sdoEn_reg;
    ctrl_next  = ctrl_reg;
    if (selFall) begin
      // msb first, bit n is output n
      shift_next = status;
      bits_next  = '0;
      any_next   = 1'b0;
      sdo_next   = status[N-1];
      sdoEn_next = 1'b1;
    end else if (!selN) begin
      if (clkFall) begin
        // sdi shifted in on falling clock
        shift_next = {shift_reg[N-2:0], sdi};
        bits_next  = bits_reg + FW'(1);
        any_next   = 1'b1;
      end
      if (clkRise) begin
        // next bit presented on rising clock
        sdo_next = shift_reg[N-1];
      end
    end
    if (selRise) begin
      // sdo released three cycles after select rises
      sdoEn_next = 1'b0;
      // only whole multiples of eight clocks latch
      // relies on select moving with clock low
      if (any_reg && bits_reg == '0) begin
        // control latches take the new word
        ctrl_next = shift_reg;
      end
    end
  end

  // common internal reset clears every latch
  always_ff @(posedge clock) begin
    if (intReset) begin
      ctrl_reg   <= odsd_pkg::CTRL_RESET;
      ovl_reg    <= '0;
      fault1_reg <= 1'b0;
      fault2_reg <= 1'b0;
      shift_reg  <= '0;
      bits_reg   <= '0;
      any_reg    <= 1'b0;
      sdo_reg    <= 1'b0;
      sdoEn_reg  <= 1'b0;
    end else begin
      ctrl_reg   <= ctrl_next;
      ovl_reg    <= ovl_next;
      fault1_reg <= fault1_next;
      fault2_reg <= fault2_next;
      shift_reg  <= shift_next;
      bits_reg   <= bits_next;
      any_reg    <= any_next;
      sdo_reg    <= sdo_next;
      sdoEn_reg  <= sdoEn_next;
    end
  end

  // outputs registered; a tripped channel stays off
  logic [7:0] out_reg;
  logic [7:0] out_next;
  logic [7:0] lim_reg;
  logic [7:0] lim_next;
  always_comb begin
    out_next = drive & ~ovl_next;
    lim_next = {drive[7:6] & ocSync[7:6] & ~ovl_next[7:6], 6'h00};
  end
  always_ff @(posedge clock) begin
    if (intReset) begin
      out_reg <= '0;
      lim_reg <= '0;
    end else begin
      out_reg <= out_next;
      lim_reg <= lim_next;
    end
  end

  assign outputOn        = out_reg;
  assign currentLimit    = lim_reg;
  assign overloadLatched = ovl_reg;
  assign controlLatch    = ctrl_reg;
  assign serialDataOut   = sdo_reg;
  assign serialDataOutEn = sdoEn_reg;
endmodule // odsd_top
`default_nettype wire

// ==== testbench/odsd_master.sv ====
// serial master model: select, clock and data towards the block
`timescale 1ns/1ps
`default_nettype none
module odsd_master (
  input  wire logic clock,
  input  wire logic serialDataOut,
  output var  logic select_n_line,
  output var  logic serialClk,
  output var  logic serialDataIn
);
  initial begin
    select_n_line = 1'b1;
    serialClk     = 1'b0;
    serialDataIn  = 1'b0;
  end
  // rx keeps the first eight sdo bits; clock stands low outside frames
  task automatic xfer(input logic [15:0] w, input int n,
                      output logic [7:0] rx);
    rx = 8'h00;
    @(posedge clock) select_n_line <= 1'b0;
    repeat (10) @(posedge clock);
    for (int i = 0; i < n; i++) begin
      serialDataIn <= w[n-1-i];
      repeat (2) @(posedge clock);
      serialClk <= 1'b1;
      // five cycles high, five low: an 80 ns serial clock
      repeat (4) @(posedge clock);
      @(negedge clock) rx[7-i%8] = (i < 8) ? serialDataOut : rx[7-i%8];
      @(posedge clock) serialClk <= 1'b0;
      repeat (3) @(posedge clock);
    end
    repeat (19) @(posedge clock);
    select_n_line <= 1'b1;
    // released data line must not keep its last level
    serialDataIn <= ~serialDataIn;
    repeat (8) @(posedge clock);
  endtask
endmodule // odsd_master
`default_nettype wire

// ==== testbench/odsd_top_checker.sv ====
// assertion checker for the octal driver serial block
`timescale 1ns/1ps
`default_nettype none
module odsd_top_checker #(
  parameter int DIAG_FILT_CYC = 4
) (
  input wire logic       clock,
  input wire logic       reset,
  input wire logic       ext_reset_n,
  input wire logic       underVoltage,
  input wire logic       select_n_line,
  input wire logic       parallel_in_one,
  input wire logic [7:0] overCurrent,
  input wire logic [7:0] overTemp,
  input wire logic       serialDataOutEn,
  input wire logic [7:0] outputOn,
  input wire logic [7:0] overloadLatched,
  input wire logic [7:0] controlLatch
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // sync latency of the pin reset is covered by the long hold
  a_pin_reset_off: assert property (
    (!ext_reset_n)[*6] |-> outputOn == 8'h00)
    else $error("outputs on during pin reset");
  a_sdo_float: assert property (
    $rose(select_n_line) |-> ##[1:12] !serialDataOutEn)
    else $error("sdo not released");
  a_sdo_drive: assert property (
    $fell(select_n_line) |-> ##[1:12] serialDataOutEn)
    else $error("sdo not driven");
  a_latch_quiet: assert property (
    (!select_n_line)[*6] |-> $stable(controlLatch))
    else $error("latch moved while selected");
  a_serial_follow: assert property (
    (outputOn[7:2] & ~$past(controlLatch[7:2])) == 6'h00)
    else $error("output on without its bit");
  a_overload_off: assert property (
    (outputOn & overloadLatched & $past(overloadLatched)) == 8'h00)
    else $error("output on while overloaded");
  a_short_trip: assert property (
    (|(overCurrent[5:0] & outputOn[5:0]))
      |-> ##[1:4] (|overloadLatched[5:0]))
    else $error("overcurrent not latched");
  a_hot_trip: assert property (
    (|(overCurrent[7:6] & overTemp[7:6] & outputOn[7:6]))
      |-> ##[1:4] (|overloadLatched[7:6]))
    else $error("overtemperature not latched");
  a_parallel_on: assert property (
    (!parallel_in_one && ext_reset_n && !underVoltage)[*6]
      |-> outputOn[0] || overloadLatched[0])
    else $error("parallel input ignored");
  c_frame: cover property ($rose(select_n_line));
  c_trip: cover property ($rose(|overloadLatched));
  c_parallel: cover property (!parallel_in_one && outputOn[0]);
endmodule // odsd_top_checker
bind odsd_top odsd_top_checker #(.DIAG_FILT_CYC(DIAG_FILT_CYC)) u_chk (
  .clock(clock), .reset(reset), .ext_reset_n(ext_reset_n),
  .underVoltage(underVoltage), .select_n_line(select_n_line),
  .parallel_in_one(parallel_in_one), .overCurrent(overCurrent),
  .overTemp(overTemp), .serialDataOutEn(serialDataOutEn),
  .outputOn(outputOn), .overloadLatched(overloadLatched),
  .controlLatch(controlLatch));
`default_nettype wire

// ==== testbench/odsd_top_test.sv ====
// self-checking bench for the octal driver serial block
`timescale 1ns/1ps
`default_nettype none
module odsd_top_test;
  logic       clock           = 1'b0;
  logic       reset           = 1'b1;
  logic       ext_reset_n     = 1'b1;
  logic       underVoltage    = 1'b0;
  logic       parallel_in_one = 1'b1;
  logic       parallel_in_two = 1'b1;
  logic [7:0] overCurrent     = 8'h00;
  logic [7:0] overTemp        = 8'h00;
  logic [7:0] aboveThreshold  = 8'hFF;
  logic [7:0] rx;
  int         n_mismatch      = 0;
  int         n_checks        = 0;
  wire        select_n_line, serialClk, serialDataIn;
  wire        serialDataOut, serialDataOutEn;
  wire  [7:0] outputOn, currentLimit, overloadLatched, controlLatch;

  always #4 clock = ~clock;

  odsd_top #(.DIAG_FILT_CYC(4)) u_odsd_top (
    .clock(clock), .reset(reset), .ext_reset_n(ext_reset_n),
    .underVoltage(underVoltage), .select_n_line(select_n_line),
    .serialClk(serialClk), .serialDataIn(serialDataIn),
    .serialDataOut(serialDataOut), .serialDataOutEn(serialDataOutEn),
    .parallel_in_one(parallel_in_one), .parallel_in_two(parallel_in_two),
    .overCurrent(overCurrent), .overTemp(overTemp),
    .aboveThreshold(aboveThreshold), .outputOn(outputOn),
    .currentLimit(currentLimit), .overloadLatched(overloadLatched),
    .controlLatch(controlLatch));
  odsd_master u_odsd_master (
    .clock(clock), .serialDataOut(serialDataOut),
    .select_n_line(select_n_line), .serialClk(serialClk),
    .serialDataIn(serialDataIn));

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] w);
    u_odsd_master.xfer({8'h00, w}, 8, rx);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic t_write;
    wr(8'hA5);
    chk(controlLatch, 8'hA5);
    chk(outputOn, 8'hA5);
  endtask
  task automatic t_filter;
    u_odsd_master.xfer(16'h0000, 7, rx);
    chk(controlLatch, 8'hA5);
    u_odsd_master.xfer(16'h0000, 0, rx);
    chk(controlLatch, 8'hA5);
    u_odsd_master.xfer(16'h3C5A, 16, rx);
    chk(controlLatch, 8'h5A);
  endtask
  // second read is the trusted one for outputs one and two
  task automatic t_status;
    @(posedge clock) aboveThreshold <= 8'hC2;
    wr(8'h5A);
    wr(8'h5A);
    chk(rx, 8'h82);
  endtask
  task automatic t_parallel;
    wr(8'h00);
    @(posedge clock) aboveThreshold <= 8'hFC;
    parallel_in_one <= 1'b0;
    parallel_in_two <= 1'b0;
    cyc(8);
    chk(outputOn, 8'h03);
    wr(8'h00);
    wr(8'h00);
    chk(rx, 8'hFF);
    @(posedge clock) aboveThreshold <= 8'hFF;
    wr(8'h00);
    wr(8'h00);
    chk(rx, 8'hFC);
    @(posedge clock) parallel_in_one <= 1'b1;
    parallel_in_two <= 1'b1;
    cyc(8);
    chk(outputOn, 8'h00);
  endtask
  task automatic t_overload;
    wr(8'hFF);
    @(posedge clock) overCurrent <= 8'h84;
    cyc(8);
    chk(overloadLatched, 8'h04);
    chk(currentLimit, 8'h80);
    chk(outputOn, 8'hFB);
    @(posedge clock) overCurrent <= 8'h80;
    overTemp <= 8'h80;
    cyc(8);
    chk(overloadLatched, 8'h84);
    chk(outputOn, 8'h7B);
    @(posedge clock) overCurrent <= 8'h00;
    overTemp <= 8'h00;
    wr(8'h7B);
    chk(rx, 8'h3B);
    chk(overloadLatched, 8'h00);
    wr(8'hFF);
    chk(outputOn, 8'hFF);
  endtask
  // a one-cycle dip stays under the filter, a long one latches
  task automatic t_glitch;
    @(posedge clock) aboveThreshold <= 8'hFE;
    @(posedge clock) aboveThreshold <= 8'hFF;
    wr(8'hFF);
    chk(rx, 8'h3F);
    @(posedge clock) aboveThreshold <= 8'hFE;
    cyc(12);
    aboveThreshold <= 8'hFF;
    wr(8'hFF);
    chk(rx, 8'h3E);
    wr(8'hFF);
    chk(rx, 8'h3F);
  endtask
  task automatic t_reset;
    for (int k = 0; k < 2; k++) begin
      wr(8'h3C);
      @(posedge clock) ext_reset_n <= (k != 0);
      underVoltage <= (k != 0);
      cyc(6);
      chk(controlLatch, 8'h00);
      chk(outputOn, 8'h00);
      @(posedge clock) ext_reset_n <= 1'b1;
      underVoltage <= 1'b0;
      cyc(6);
    end
  endtask

  initial begin
    cyc(20);
    reset <= 1'b0;
    cyc(6);
    t_write;
    t_filter;
    t_status;
    t_parallel;
    t_overload;
    t_glitch;
    t_reset;
    close_out;
  end
  // nineteen frames, most of some 120 cycles each, wide margin
  initial begin
    cyc(20000);
    n_mismatch++;
    close_out;
  end
endmodule // odsd_top_test
`default_nettype wire
